// *** hw/pig_port.sv ***
// GPIO port logic for ports A (6 pins), C (2 pins) and D (8 internal pins).
// Assumes pins and peripheral signals are synchronous to clk_sys; pin pads resolve
// the wire from value and active-low enable outside this module.
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "pig_defines.svh"

module pig_port (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [8:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq,
    input  wire logic [5:0]  pa_in,
    output logic      [5:0]  pa_out,
    output logic      [5:0]  pa_oe_n,
    output logic      [5:0]  pa_reduced,
    input  wire logic [1:0]  pc_in,
    output logic      [1:0]  pc_out,
    output logic      [1:0]  pc_oe_n,
    output logic             pc_pulldown,
    input  wire logic [7:0]  pd_in,
    output logic      [7:0]  pd_out,
    output logic      [7:0]  pd_oe_n,
    output logic      [7:0]  pd_pulldown,
    input  wire logic [3:0]  spi_out,
    input  wire logic [3:0]  spi_oe,
    output logic      [3:0]  spi_in,
    input  wire logic        link_clk_out,
    input  wire logic [7:0]  link_dat_out,
    input  wire logic [7:0]  link_dat_oe,
    output logic      [7:0]  link_dat_in,
    output logic             link_irq_in,
    input  wire logic        stop_mode,
    output logic             link_wake
);

    logic [7:0]  data_a_ff, data_c_ff, data_d_ff;
    logic [7:0]  dir_a_ff, dir_c_ff, dir_d_ff;
    logic [7:0]  drv_a_ff, ctrl_ff, sts_ff, msk_ff;
    logic [5:0]  a_s1_ff, a_sync_ff, a_old_ff;
    logic [1:0]  c_s1_ff, c_sync_ff;
    logic [7:0]  d_s1_ff, d_sync_ff;
    logic        lirq_old_ff;
    logic [31:0] rdata_ff;
    pig_pkg::pig_bus_t state_ff;
    logic        req, wr_go, wr_lane;
    logic        spi_en, link_en;
    logic [7:0]  lanes, wdat, rd_val, nxt_sts;
    logic [5:0]  a_drive;

    // Read value of a data register: pin level for inputs, stored bit for outputs
    function automatic logic [7:0] data_rd(input logic [7:0] dir,
                                           input logic [7:0] stored,
                                           input logic [7:0] pin);
        data_rd = (dir & stored) | (~dir & pin); // RQ3
    endfunction

    assign spi_en  = ctrl_ff[`PIG_CTRL_SPI_EN];
    assign link_en = ctrl_ff[`PIG_CTRL_LINK_EN];
    assign req     = avs_read | avs_write;
    assign wr_lane = avs_write & avs_byteenable[0];
    assign wr_go   = wr_lane & (state_ff == pig_pkg::PIG_ACK);
    assign wdat    = avs_writedata[7:0];

    // One wait cycle per access so read data can come from a flip-flop
    assign avs_waitrequest = (state_ff != pig_pkg::PIG_ACK);
    assign avs_readdata    = rdata_ff;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff <= pig_pkg::PIG_IDLE;
        end else begin
            case (state_ff)
                pig_pkg::PIG_IDLE: begin
                    if (req) begin
                        state_ff <= pig_pkg::PIG_ACK;
                    end
                end
                pig_pkg::PIG_ACK: state_ff <= pig_pkg::PIG_IDLE;
                default: state_ff <= pig_pkg::PIG_IDLE;
            endcase
        end
    end

    // Read mux; reserved and unmapped words answer zero
    always_comb begin
        case (avs_address)
            `PIG_IDX_DATA_A:  rd_val = data_rd(dir_a_ff, data_a_ff, {2'b00, a_sync_ff});
            `PIG_IDX_DATA_C:  rd_val = data_rd(dir_c_ff, data_c_ff, {6'h00, c_sync_ff});
            `PIG_IDX_DATA_D:  rd_val = data_rd(dir_d_ff, data_d_ff, d_sync_ff);
            `PIG_IDX_DIR_A:   rd_val = dir_a_ff;
            `PIG_IDX_DIR_C:   rd_val = dir_c_ff;
            `PIG_IDX_DIR_D:   rd_val = dir_d_ff;
            `PIG_IDX_LVL_A:   rd_val = {2'b00, a_sync_ff}; // RQ5
            `PIG_IDX_LVL_C:   rd_val = {6'h00, c_sync_ff}; // RQ5
            `PIG_IDX_LVL_D:   rd_val = d_sync_ff;          // RQ5
            `PIG_IDX_CTRL:    rd_val = ctrl_ff;
            `PIG_IDX_IRQ_STS: rd_val = sts_ff;
            `PIG_IDX_IRQ_MSK: rd_val = msk_ff;
            `PIG_IDX_DRV_A:   rd_val = drv_a_ff;           // RQ7
            default:          rd_val = `PIG_RST_REG;       // RQ8
        endcase
    end

    // Read data captured at request, held through the answer cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_ff <= 32'h0000_0000;
        end else if (state_ff == pig_pkg::PIG_IDLE && avs_read) begin
            rdata_ff <= {24'h00_0000, rd_val};
        end
    end

    // Data and direction registers; peripherals never touch the direction bits
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            data_a_ff <= `PIG_RST_REG;
            data_c_ff <= `PIG_RST_REG;
            data_d_ff <= `PIG_RST_REG;
            dir_a_ff  <= `PIG_RST_REG;
            dir_c_ff  <= `PIG_RST_REG;
            dir_d_ff  <= `PIG_RST_REG;
        end else if (wr_go) begin
            case (avs_address)
                `PIG_IDX_DATA_A: data_a_ff <= {2'b00, wdat[5:0]}; // RQ2
                `PIG_IDX_DATA_C: data_c_ff <= {6'h00, wdat[1:0]}; // RQ2
                `PIG_IDX_DATA_D: data_d_ff <= wdat;               // RQ2
                `PIG_IDX_DIR_A:  dir_a_ff  <= {2'b00, wdat[5:0]}; // RQ4
                `PIG_IDX_DIR_C:  dir_c_ff  <= {6'h00, wdat[1:0]}; // RQ4
                `PIG_IDX_DIR_D:  dir_d_ff  <= wdat;               // RQ4
                default: ;
            endcase
        end
    end

    // Control and drive select; input and reserved words drop writes
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_ff  <= `PIG_RST_REG;
            drv_a_ff <= `PIG_RST_REG; // RQ7
            msk_ff   <= `PIG_RST_REG;
        end else if (wr_go) begin
            case (avs_address)
                `PIG_IDX_CTRL:    ctrl_ff  <= wdat & `PIG_CTRL_MASK;
                `PIG_IDX_DRV_A:   drv_a_ff <= wdat & `PIG_DRV_MASK; // RQ7
                `PIG_IDX_IRQ_MSK: msk_ff   <= wdat & `PIG_STS_MASK;
                default: ;        // RQ5 RQ8
            endcase
        end
    end

    // Two-stage pin synchronisers; only the second stage feeds anything
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            a_s1_ff   <= 6'h00;
            a_sync_ff <= 6'h00;
            c_s1_ff   <= 2'h0;
            c_sync_ff <= 2'h0;
            d_s1_ff   <= 8'h00;
            d_sync_ff <= 8'h00;
        end else begin
            a_s1_ff   <= pa_in; // RQ19
            a_sync_ff <= a_s1_ff;
            c_s1_ff   <= pc_in; // RQ12
            c_sync_ff <= c_s1_ff;
            d_s1_ff   <= pd_in;
            d_sync_ff <= d_s1_ff;
        end
    end

    // Port A: lower four go to the serial interface when enabled, upper two stay GPIO
    assign a_drive[5:4] = dir_a_ff[5:4];                      // RQ1
    assign a_drive[3:0] = spi_en ? spi_oe : dir_a_ff[3:0];    // RQ9 RQ4
    assign pa_out[5:4]  = data_a_ff[5:4];
    assign pa_out[3:0]  = spi_en ? spi_out : data_a_ff[3:0];  // RQ9
    assign pa_oe_n      = ~a_drive;                           // RQ18
    assign pa_reduced   = drv_a_ff[5:0] & a_drive;            // RQ6
    assign spi_in       = a_sync_ff[3:0];

    // Port C: upper pin is the link interrupt input, lower the link clock
    assign pc_out[1]   = data_c_ff[1];
    assign pc_out[0]   = link_en ? link_clk_out : data_c_ff[0]; // RQ10
    assign pc_oe_n[1]  = link_en | ~dir_c_ff[1];                // RQ10 RQ18
    assign pc_oe_n[0]  = ~(link_en | dir_c_ff[0]);              // RQ10
    assign pc_pulldown = link_en;                               // RQ11
    assign link_irq_in = link_en & c_sync_ff[1];                // RQ12

    // Stop clocks halt the synchroniser, so the raw pin wakes the core directly
    assign link_wake = stop_mode & link_en & pc_in[1]; // RQ12

    // Port D: link lanes by mode, others left to GPIO
    assign lanes = link_en ? (ctrl_ff[`PIG_CTRL_WIDE] ? `PIG_LANES_WIDE
                                                      : `PIG_LANES_NARROW)
                           : 8'h00;                                   // RQ17 RQ13
    assign pd_out      = (lanes & link_dat_out) | (~lanes & data_d_ff);
    assign pd_oe_n     = ~((lanes & link_dat_oe) | (~lanes & dir_d_ff)); // RQ4 RQ13
    assign pd_pulldown = lanes & ~link_dat_oe;                        // RQ14
    assign link_dat_in = d_sync_ff & lanes;

    // Event history for edge detection on synchronised levels
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            a_old_ff    <= 6'h00;
            lirq_old_ff <= 1'b0;
        end else begin
            a_old_ff    <= a_sync_ff;
            lirq_old_ff <= link_irq_in;
        end
    end

    // Sticky status, write one to clear; a new event wins over the clear
    always_comb begin
        nxt_sts = sts_ff;
        if (wr_go && avs_address == `PIG_IDX_IRQ_STS) begin
            nxt_sts = sts_ff & ~wdat;
        end
        if (link_irq_in && !lirq_old_ff) begin
            nxt_sts[`PIG_STS_LINK_IRQ] = 1'b1;
        end
        if (a_sync_ff != a_old_ff) begin
            nxt_sts[`PIG_STS_A_CHG] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sts_ff <= `PIG_RST_REG;
        end else begin
            sts_ff <= nxt_sts & `PIG_STS_MASK;
        end
    end

    assign irq = |(sts_ff & msk_ff);

    // Checks
    property p_rsvd_zero;
        @(posedge clk_sys) disable iff (rst)
        (state_ff == pig_pkg::PIG_IDLE && avs_read && avs_address >= `PIG_IDX_RSV_LO
         && avs_address <= `PIG_IDX_RSV_HI) |=> (avs_readdata == 32'h0000_0000);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("Reserved word read non-zero"); // RQ8

    property p_drv_reset;
        @(posedge clk_sys) rst |=> (drv_a_ff == 8'h00);
    endproperty
    a_drv_reset: assert property (p_drv_reset) else $error("Drive select not cleared"); // RQ7

    property p_drv_upper;
        @(posedge clk_sys) disable iff (rst)
        wr_go && avs_address == `PIG_IDX_DRV_A |=> drv_a_ff[7:6] == 2'b00
            && drv_a_ff[5:0] == $past(avs_writedata[5:0]);
    endproperty
    a_drv_upper: assert property (p_drv_upper) else $error("Drive select write wrong"); // RQ7

    property p_reduced_in;
        @(posedge clk_sys) disable iff (rst)
        (pa_reduced & ~pa_oe_n) == pa_reduced;
    endproperty
    a_reduced_in: assert property (p_reduced_in) else $error("Reduced drive on input"); // RQ6

    property p_sync_two;
        @(posedge clk_sys) disable iff (rst)
        !$past(rst, 2) |-> (a_sync_ff == $past(pa_in, 2));
    endproperty
    a_sync_two: assert property (p_sync_two) else $error("Pin sync latency wrong"); // RQ19

    property p_level_read;
        @(posedge clk_sys) disable iff (rst)
        state_ff == pig_pkg::PIG_IDLE && avs_read && avs_address == `PIG_IDX_LVL_D
            |=> avs_readdata[7:0] == $past(d_sync_ff);
    endproperty
    a_level_read: assert property (p_level_read) else $error("Level read wrong"); // RQ5

    property p_dir_kept;
        @(posedge clk_sys) disable iff (rst)
        !wr_go && link_en |=> $stable(dir_d_ff) && $stable(dir_c_ff);
    endproperty
    a_dir_kept: assert property (p_dir_kept) else $error("Direction bit moved"); // RQ4

    property p_narrow_gpio;
        @(posedge clk_sys) disable iff (rst)
        link_en && !ctrl_ff[`PIG_CTRL_WIDE]
            |-> pd_oe_n[7:4] == ~dir_d_ff[7:4] && pd_out[7:4] == data_d_ff[7:4];
    endproperty
    a_narrow_gpio: assert property (p_narrow_gpio) else $error("Upper D not GPIO"); // RQ13

    property p_pc_pull;
        @(posedge clk_sys) disable iff (rst)
        link_en |-> pc_pulldown && pc_oe_n[1] && !pc_oe_n[0];
    endproperty
    a_pc_pull: assert property (p_pc_pull) else $error("Port C link setup wrong"); // RQ11

    property p_lirq_event;
        @(posedge clk_sys) disable iff (rst)
        link_en && $rose(c_sync_ff[1]) |=> sts_ff[`PIG_STS_LINK_IRQ];
    endproperty
    a_lirq_event: assert property (p_lirq_event) else $error("Link irq lost"); // RQ12

    // Upper port A pins have no peripheral, so they always follow their registers
    property p_upper_gpio;
        @(posedge clk_sys) disable iff (rst)
        pa_out[5:4] == data_a_ff[5:4] && pa_oe_n[5:4] == ~dir_a_ff[5:4];
    endproperty
    a_upper_gpio: assert property (p_upper_gpio) else $error("Upper A pins not GPIO"); // RQ1

    property p_gpio_out;
        @(posedge clk_sys) disable iff (rst)
        !spi_en |-> pa_oe_n == ~dir_a_ff[5:0] && pa_out == data_a_ff[5:0];
    endproperty
    a_gpio_out: assert property (p_gpio_out) else $error("Port A GPIO wrong"); // RQ18

    property p_data_drive;
        @(posedge clk_sys) disable iff (rst)
        !link_en |-> pd_out == data_d_ff && pc_out == data_c_ff[1:0];
    endproperty
    a_data_drive: assert property (p_data_drive) else $error("Data reg not on pins"); // RQ2

    property p_spi_pins;
        @(posedge clk_sys) disable iff (rst)
        spi_en |-> pa_out[3:0] == spi_out && pa_oe_n[3:0] == ~spi_oe;
    endproperty
    a_spi_pins: assert property (p_spi_pins) else $error("Serial pins wrong"); // RQ9

    property p_wide_lanes;
        @(posedge clk_sys) disable iff (rst)
        link_en && ctrl_ff[`PIG_CTRL_WIDE]
            |-> pd_out == link_dat_out && pd_oe_n == ~link_dat_oe;
    endproperty
    a_wide_lanes: assert property (p_wide_lanes) else $error("Wide lanes wrong"); // RQ17

    // A pull-down fighting a driven lane would waste current, so never both
    property p_pd_pull;
        @(posedge clk_sys) disable iff (rst)
        (pd_pulldown & ~pd_oe_n) == 8'h00 && (link_en || pd_pulldown == 8'h00);
    endproperty
    a_pd_pull: assert property (p_pd_pull) else $error("Port D pull-down wrong"); // RQ14

    property p_wake;
        @(posedge clk_sys) disable iff (rst)
        stop_mode && link_en && pc_in[1] |-> link_wake;
    endproperty
    a_wake: assert property (p_wake) else $error("Wake bypass missing"); // RQ12

    property p_data_read;
        @(posedge clk_sys) disable iff (rst)
        state_ff == pig_pkg::PIG_IDLE && avs_read && avs_address == `PIG_IDX_DATA_A
            |=> avs_readdata[5:0] == (($past(dir_a_ff[5:0]) & $past(data_a_ff[5:0]))
                | (~$past(dir_a_ff[5:0]) & $past(a_sync_ff)));
    endproperty
    a_data_read: assert property (p_data_read) else $error("Data read wrong"); // RQ3

endmodule

// *** pkg/pig_defines.svh ***
// Register indices, field positions, masks and reset values of the GPIO port block.
// Assumes a 32-bit word-addressed register bus; byte address is four times the index.
//
// Behaviour
// RQ1: Every pin is GPIO; all but port A upper pins also serve peripherals.
// RQ2: Data register holds pin drive value; writes reach pin only as GPIO output.
// RQ3: Data read returns synchronised pin when direction 0, stored value when 1.
// RQ4: Peripheral-owned pins ignore their direction bit, which itself stays unchanged.
// RQ5: Input register is read-only, always returns synchronised pin level.
// RQ6: Port A drive-select bit set gives one-sixth drive; no effect on inputs.
// RQ7: Drive-select register readable/writable anytime; upper two bits zero; resets zero.
// RQ8: Reserved range after drive-select reads zero; writes ignored.
// RQ9: All port A pins are GPIO; lower four also carry serial interface.
// RQ10: Port C pins: GPIO, or link interrupt input (upper) and link clock (lower).
// RQ11: Pull-down on upper port C pin while it is the link interrupt input.
// RQ12: Link interrupt input synchronised; stop mode bypass raises asynchronous wake-up.
// RQ13: Port D pins GPIO or link data; 4-bit mode leaves upper four GPIO.
// RQ14: Pull-downs on port D pins while acting as link inputs.
// RQ15: Software avoids writing data and direction in one word access.
// RQ16: Software loads data register before turning pins into outputs.
// RQ17: 8-bit link mode uses all port D pins; 4-bit mode lower four.
// RQ18: Direction one makes pin output; zero makes high-impedance input.
// RQ19: Pin levels pass two flip-flops before reaching read paths.
`ifndef PIG_DEFINES_SVH
`define PIG_DEFINES_SVH

// Register indices (word addresses)
`define PIG_IDX_DATA_A   9'h100
`define PIG_IDX_DATA_C   9'h101
`define PIG_IDX_DATA_D   9'h102
`define PIG_IDX_DIR_A    9'h103
`define PIG_IDX_DIR_C    9'h104
`define PIG_IDX_DIR_D    9'h105
`define PIG_IDX_LVL_A    9'h106
`define PIG_IDX_LVL_C    9'h107
`define PIG_IDX_LVL_D    9'h108
`define PIG_IDX_CTRL     9'h110
`define PIG_IDX_IRQ_STS  9'h111
`define PIG_IDX_IRQ_MSK  9'h112
`define PIG_IDX_DRV_A    9'h122
`define PIG_IDX_RSV_LO   9'h123
`define PIG_IDX_RSV_HI   9'h17F

// Control fields
`define PIG_CTRL_SPI_EN  0
`define PIG_CTRL_LINK_EN 1
`define PIG_CTRL_WIDE    2
`define PIG_CTRL_MASK    8'h07

// Status fields
`define PIG_STS_LINK_IRQ 0
`define PIG_STS_A_CHG    1
`define PIG_STS_MASK     8'h03

// Field masks and reset values
`define PIG_DRV_MASK     8'h3F
`define PIG_RST_REG      8'h00
`define PIG_LANES_WIDE   8'hFF
`define PIG_LANES_NARROW 8'h0F

`endif

// *** pkg/pig_pkg.sv ***
// Types shared by the GPIO port block.
// Assumes the constants header is compiled alongside.
package pig_pkg;
    // Register bus handshake states
    typedef enum logic [0:0] {
        PIG_IDLE = 1'b0,
        PIG_ACK  = 1'b1
    } pig_bus_t;
endpackage

// *** verification/pig_pins_model.sv ***
// Far side of the GPIO pins: outside drivers on ports A and C and the link's lines on D.
// Assumes the device's enables are active low and the far side drives every released line.
`timescale 1ns/1ps
module pig_pins_model (
    input  wire logic [5:0] pa_out,
    input  wire logic [5:0] pa_oe_n,
    input  wire logic [5:0] pa_ext,
    output logic      [5:0] pa_in,
    input  wire logic [1:0] pc_out,
    input  wire logic [1:0] pc_oe_n,
    input  wire logic [1:0] pc_ext,
    output logic      [1:0] pc_in,
    input  wire logic [7:0] pd_out,
    input  wire logic [7:0] pd_oe_n,
    input  wire logic [7:0] pd_ext,
    output logic      [7:0] pd_in
);
    // The device wins where it drives; a released pin shows the far side's level
    assign pa_in = (pa_out & ~pa_oe_n) | (pa_ext & pa_oe_n);
    assign pc_in = (pc_out & ~pc_oe_n) | (pc_ext & pc_oe_n);
    assign pd_in = (pd_out & ~pd_oe_n) | (pd_ext & pd_oe_n);
endmodule

// *** verification/tb.sv ***
// Self-checking bench of the GPIO port block against an integer model of its registers.
// Assumes the one-wait-state register bus of the block and pins settled 4 cycles before reads.
`timescale 1ns/1ps
module tb;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [8:0]  avs_address = 9'h000;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest, irq, pc_pulldown, link_irq_in, link_wake;
    logic [5:0]  pa_in, pa_out, pa_oe_n, pa_reduced;
    logic [1:0]  pc_in, pc_out, pc_oe_n;
    logic [7:0]  pd_in, pd_out, pd_oe_n, pd_pulldown, link_dat_in;
    logic [3:0]  spi_in;
    logic [5:0]  ext_a = 6'h00;
    logic [1:0]  ext_c = 2'h0;
    logic [7:0]  ext_d = 8'h00;
    logic [7:0]  link_dat_out = 8'h00;
    logic [7:0]  link_dat_oe = 8'h00;
    logic [3:0]  spi_out = 4'h0;
    logic [3:0]  spi_oe = 4'h0;
    logic        link_clk_out = 1'b0;
    logic        stop_mode = 1'b0;
    logic [31:0] rs = 32'h0000_0bde;
    int          failures = 0;
    int          n_compared = 0;
    int          m_dat[3], m_dir[3], m_ctrl, m_drv, m_sts, m_msk, m_pa, m_pc1, m_lv;
    int          wmk[3] = '{8'h3F, 8'h03, 8'hFF};
    logic [8:0]  idx[17] = '{9'h100, 9'h101, 9'h102, 9'h103, 9'h104, 9'h105, 9'h106, 9'h107,
                             9'h108, 9'h110, 9'h111, 9'h112, 9'h122, 9'h123, 9'h17F, 9'h140,
                             9'h1FF};

    pig_port u_pig_port (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .pa_in(pa_in), .pa_out(pa_out),
        .pa_oe_n(pa_oe_n), .pa_reduced(pa_reduced), .pc_in(pc_in), .pc_out(pc_out),
        .pc_oe_n(pc_oe_n), .pc_pulldown(pc_pulldown), .pd_in(pd_in), .pd_out(pd_out),
        .pd_oe_n(pd_oe_n), .pd_pulldown(pd_pulldown), .spi_out(spi_out), .spi_oe(spi_oe),
        .spi_in(spi_in), .link_clk_out(link_clk_out), .link_dat_out(link_dat_out),
        .link_dat_oe(link_dat_oe), .link_dat_in(link_dat_in), .link_irq_in(link_irq_in),
        .stop_mode(stop_mode), .link_wake(link_wake));

    pig_pins_model u_pig_pins_model (.pa_out(pa_out), .pa_oe_n(pa_oe_n), .pa_ext(ext_a),
        .pa_in(pa_in), .pc_out(pc_out), .pc_oe_n(pc_oe_n), .pc_ext(ext_c), .pc_in(pc_in),
        .pd_out(pd_out), .pd_oe_n(pd_oe_n), .pd_ext(ext_d), .pd_in(pd_in));

    // 40 MHz clock
    always #12.5 clk_sys = ~clk_sys;

    // Xorshift source; fixed start keeps runs repeatable
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction

    // Model: link lanes, which pins the device drives, what it drives, resolved levels
    function automatic int lanes();
        return m_ctrl[1] ? (m_ctrl[2] ? 8'hFF : 8'h0F) : 8'h00;
    endfunction
    function automatic int drv(int p);
        if (p == 0) return m_ctrl[0] ? (m_dir[0] & 8'h30) | spi_oe : m_dir[0];
        if (p == 1) return m_ctrl[1] ? 1 : m_dir[1];
        return (m_dir[2] & ~lanes()) | (lanes() & link_dat_oe);
    endfunction
    function automatic int outv(int p);
        if (p == 0) return m_ctrl[0] ? (m_dat[0] & 8'h30) | spi_out : m_dat[0];
        if (p == 1) return m_ctrl[1] ? (m_dat[1] & 2'h2) | link_clk_out : m_dat[1];
        return (m_dat[2] & ~lanes()) | (lanes() & link_dat_out);
    endfunction
    function automatic int pin(int p);
        int e;
        e = (p == 0) ? ext_a : (p == 1) ? ext_c : ext_d;
        return (drv(p) & outv(p)) | (~drv(p) & e & wmk[p]);
    endfunction
    function automatic int mread(logic [8:0] a);
        int p;
        p = a - 9'h100;
        case (a)
            9'h100, 9'h101, 9'h102: return (m_dir[p] & m_dat[p]) | (~m_dir[p] & pin(p));
            9'h103, 9'h104, 9'h105: return m_dir[p - 3];
            9'h106, 9'h107, 9'h108: return pin(p - 6);
            9'h110: return m_ctrl;
            9'h111: return m_sts;
            9'h112: return m_msk;
            9'h122: return m_drv;
            default: return 0;
        endcase
    endfunction
    task automatic mwrite(logic [8:0] a, int d);
        int p;
        p = a - 9'h100;
        case (a)
            9'h100, 9'h101, 9'h102: m_dat[p] = d & wmk[p];
            9'h103, 9'h104, 9'h105: m_dir[p - 3] = d & wmk[p - 3];
            9'h110: m_ctrl = d & 8'h07;
            9'h111: m_sts = m_sts & ~d;
            9'h112: m_msk = d & 8'h03;
            9'h122: m_drv = d & 8'h3F;
            default: ;
        endcase
    endtask
    // Event bits; a link enable sees the old pin level before the new wiring settles
    task automatic mupd();
        int l;
        if (pin(0) != m_pa) m_sts = m_sts | 2;
        m_pa = pin(0);
        l = m_ctrl[1] & m_pc1;
        if (l && !m_lv) m_sts = m_sts | 1;
        m_pc1 = (pin(1) >> 1) & 1;
        if ((m_ctrl[1] & m_pc1) && !l) m_sts = m_sts | 1;
        m_lv = m_ctrl[1] & m_pc1;
    endtask

    // Bus master: holds the request until waitrequest is seen low, bounded wait
    task automatic bus(logic wr, logic [8:0] a, logic [31:0] d, logic [3:0] be,
                       output logic [31:0] q);
        int k;
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        for (k = 0; k < 16; k++) begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (k == 16) begin
            failures++;
            end_sim();
        end
    endtask

    // Comparisons: register read data and pin-side outputs
    task automatic chk_reg(logic [31:0] got, logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(logic [45:0] got, logic [45:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("compared=%0d failures=%0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Random pins, peripherals and one register write per step, two for a direction register (data first), then every register read back
    initial begin
        int          i, j;
        logic [8:0]  a;
        logic [31:0] d, q;
        logic [3:0]  be;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        for (i = 0; i < 300; i++) begin
            @(posedge clk_sys);
            ext_a <= 6'(rnd());
            ext_c <= 2'(rnd());
            ext_d <= 8'(rnd());
            spi_out <= 4'(rnd());
            spi_oe <= 4'(rnd());
            link_clk_out <= 1'(rnd());
            link_dat_out <= 8'(rnd());
            link_dat_oe <= 8'(rnd());
            stop_mode <= 1'(rnd());
            repeat (4) @(posedge clk_sys);
            mupd();
            a = idx[rnd() % 17];
            if (a >= 9'h103 && a <= 9'h105) begin
                d = rnd();
                bus(1'b1, a - 9'h003, d, 4'h1, q);
                mwrite(a - 9'h003, d);
                mupd();
            end
            d = rnd();
            be = 4'(rnd());
            bus(1'b1, a, d, be, q);
            if (be[0]) mwrite(a, d);
            mupd();
            repeat (4) @(posedge clk_sys);
            chk_pin({pa_oe_n, pc_oe_n, pd_oe_n, pa_reduced, pc_pulldown, pd_pulldown, spi_in,
                     link_dat_in, link_irq_in, link_wake, irq},
                    {6'(~drv(0)), 2'(~drv(1)), 8'(~drv(2)), 6'(m_drv & drv(0)), m_ctrl[1],
                     8'(lanes() & ~link_dat_oe), 4'(pin(0)), 8'(pin(2) & lanes()), 1'(m_lv),
                     1'(m_lv) & stop_mode,
                     1'((m_sts & m_msk) != 0)});
            chk_pin({pa_out & ~pa_oe_n, pc_out & ~pc_oe_n,
                     pd_out & ~pd_oe_n},
                    {6'(outv(0) & drv(0)), 2'(outv(1) & drv(1)), 8'(outv(2) & drv(2))});
            for (j = 0; j < 17; j++) begin
                bus(1'b0, idx[j], rnd(), 4'hF, q);
                chk_reg(q, 32'(mread(idx[j])));
            end
        end
        end_sim();
    end
endmodule
